// ### core/crcg_pkg.sv
// Summary of operation
// - 16-bit CRC, x16+x12+x5+1, LSB first
// - Each data write folds one byte
// - Halted CPU: scan program memory by words
// - Byte result visible on next clock edge
// - Result register writable seed, resets all ones
// - Halt with enable set starts range scan
// - Scan completion clears enable bit
// - Start registers are the live read pointer
// - Address bits one and zero stay zero
// - Enable set: start/end address writes dropped
// - Enable set: segment, data, result writes dropped
// - Reset end to 0xFFFC, segment fifteen
// - Enable bit: zero off, one on
// - Halt exit pauses; next halt resumes
// - Done when pointer meets end; no wake
package crcg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] CRCG_OFS_START_ADDR = 16'hf0d0;
  localparam logic [15:0] CRCG_OFS_END_ADDR   = 16'hf0d2;
  localparam logic [15:0] CRCG_OFS_START_SEG  = 16'hf0d4;
  localparam logic [15:0] CRCG_OFS_END_SEG    = 16'hf0d6;
  localparam logic [15:0] CRCG_OFS_BYTE_IN    = 16'hf0d8;
  localparam logic [15:0] CRCG_OFS_RESULT     = 16'hf0da;
  localparam logic [15:0] CRCG_OFS_CONTROL    = 16'hf0dc;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CRCG_RST_START_ADDR = 16'h0000;
  localparam logic [15:0] CRCG_RST_END_ADDR   = 16'hfffc;
  localparam logic [7:0]  CRCG_RST_START_SEG  = 8'h00;
  localparam logic [7:0]  CRCG_RST_END_SEG    = 8'h0f;
  localparam logic [7:0]  CRCG_RST_BYTE_IN    = 8'h00;
  localparam logic [15:0] CRCG_RST_RESULT     = 16'hffff;
  localparam logic [7:0]  CRCG_RST_CONTROL    = 8'h00;

  // ----------------------------------------------------------------
  // Fields and arithmetic
  // ----------------------------------------------------------------
  localparam int          CRCG_AEN_BIT   = 0;
  localparam int          CRCG_ALIGN_LSB = 2;
  localparam logic [15:0] CRCG_POLY_REFL = 16'h8408;
  localparam logic [13:0] CRCG_WORD_STEP = 14'h0001;
  localparam logic [7:0]  CRCG_SEG_STEP  = 8'h01;

  // ----------------------------------------------------------------
  // Scan states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    CRCG_SCAN_IDLE  = 1'b0,
    CRCG_SCAN_FETCH = 1'b1
  } crcg_scan_e;

endpackage : crcg_pkg

// ### core/crcg_byte_fold.sv
`timescale 1ns/100ps

// Folds one byte into a running CRC, bit 0 of the byte first
module crcg_byte_fold
  import crcg_pkg::*;
(
  input  wire logic [15:0] crc_in,   // Running CRC before the byte
  input  wire logic [7:0]  data_in,  // Byte to fold
  output logic      [15:0] crc_out   // Running CRC after the byte
);

  // ----------------------------------------------------------------
  // Bitwise reflected update
  // ----------------------------------------------------------------
  // Shift right; when the bit shifted out differs from the data bit, xor the reflected polynomial
  always_comb begin
    logic [15:0] acc;
    logic        fb;
    acc = crc_in;
    fb  = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb  = acc[0] ^ data_in[i];
      acc = {1'b0, acc[15:1]};
      if (fb) begin
        acc = acc ^ CRCG_POLY_REFL;
      end
    end
    crc_out = acc;
  end

endmodule : crcg_byte_fold

// ### core/crcg_top.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps

// CRC generator with software byte feed and halt-time program memory scan
module crcg_top
  import crcg_pkg::*;
(
  input  wire logic        core_clk,   // System clock, 25 MHz
  input  wire logic        rst_b,      // Synchronous reset, active low
  input  wire logic [15:0] reg_addr,   // Register byte address
  input  wire logic [15:0] reg_wdata,  // Register write data
  input  wire logic        reg_wr,     // Write strobe, one cycle
  input  wire logic        reg_rd,     // Read strobe, one cycle
  output logic      [15:0] reg_rdata,  // Read data, cycle after strobe
  input  wire logic        cpu_halt,   // CPU in halt or deep halt
  output logic             pm_req,     // Program memory fetch request
  output logic      [7:0]  pm_seg,     // Fetch segment
  output logic      [15:0] pm_addr,    // Fetch address, word aligned
  input  wire logic        pm_ack,     // Fetch data valid
  input  wire logic [31:0] pm_rdata,   // Fetched word, low byte lowest
  output logic             auto_busy   // Enable bit, for status
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [13:0] start_addr_ff;
  logic [13:0] end_addr_ff;
  logic [7:0]  start_seg_ff;
  logic [7:0]  end_seg_ff;
  logic [7:0]  byte_in_ff;
  logic [15:0] crc_ff;
  logic        aen_ff;
  logic [15:0] rdata_ff;
  crcg_scan_e  scan_ff;

  logic [13:0] nxt_start_addr;
  logic [13:0] nxt_end_addr;
  logic [7:0]  nxt_start_seg;
  logic [7:0]  nxt_end_seg;
  logic [7:0]  nxt_byte_in;
  logic [15:0] nxt_crc;
  logic        nxt_aen;
  logic [15:0] nxt_rdata;
  crcg_scan_e  nxt_scan;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word registers answer only at their even address
  wire hit_start_addr = (reg_addr == CRCG_OFS_START_ADDR);
  wire hit_end_addr   = (reg_addr == CRCG_OFS_END_ADDR);
  wire hit_start_seg  = (reg_addr == CRCG_OFS_START_SEG);
  wire hit_end_seg    = (reg_addr == CRCG_OFS_END_SEG);
  wire hit_byte_in    = (reg_addr == CRCG_OFS_BYTE_IN);
  wire hit_result     = (reg_addr == CRCG_OFS_RESULT);
  wire hit_control    = (reg_addr == CRCG_OFS_CONTROL);

  // Writes to range, data and result are refused while the scan is armed
  wire wr_open        = reg_wr && !aen_ff;
  wire wr_start_addr  = wr_open && hit_start_addr;
  wire wr_end_addr    = wr_open && hit_end_addr;
  wire wr_start_seg   = wr_open && hit_start_seg;
  wire wr_end_seg     = wr_open && hit_end_seg;
  wire wr_byte_in     = wr_open && hit_byte_in;
  wire wr_result      = wr_open && hit_result;
  wire wr_control     = reg_wr && hit_control;

  // ----------------------------------------------------------------
  // CRC datapath
  // ----------------------------------------------------------------
  logic [15:0] man_crc;
  logic [15:0] chain_crc [0:4];

  // Software path: one byte per write
  crcg_byte_fold u_man_fold (
    .crc_in  (crc_ff),
    .data_in (reg_wdata[7:0]),
    .crc_out (man_crc)
  );

  // Scan path: four bytes of the fetched word, lowest address first
  assign chain_crc[0] = crc_ff;
  for (genvar g = 0; g < 4; g++) begin : g_word_fold
    crcg_byte_fold u_fold (
      .crc_in  (chain_crc[g]),
      .data_in (pm_rdata[8*g +: 8]),
      .crc_out (chain_crc[g+1])
    );
  end

  wire [15:0] word_crc = chain_crc[4];

  // ----------------------------------------------------------------
  // Scan control
  // ----------------------------------------------------------------
  // A fetch starts only while armed and the CPU is halted
  wire scan_go     = aen_ff && cpu_halt;
  wire fetch_done  = (scan_ff == CRCG_SCAN_FETCH) && pm_ack;
  wire at_end      = (start_seg_ff == end_seg_ff) && (start_addr_ff == end_addr_ff);
  wire range_done  = fetch_done && at_end;

  // Pointer step: address word index with carry into the segment
  wire [14:0] addr_sum  = {1'b0, start_addr_ff} + {1'b0, CRCG_WORD_STEP};
  wire [13:0] addr_inc  = addr_sum[13:0];
  wire [7:0]  seg_inc   = addr_sum[14] ? (start_seg_ff + CRCG_SEG_STEP) : start_seg_ff;

  // Next scan state: a fetch in flight always completes, then the halt level decides
  always_comb begin
    nxt_scan = scan_ff;
    unique case (scan_ff)
      CRCG_SCAN_IDLE: begin
        if (scan_go) begin
          nxt_scan = CRCG_SCAN_FETCH;
        end
      end
      CRCG_SCAN_FETCH: begin
        if (pm_ack) begin
          nxt_scan = CRCG_SCAN_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  // Start pointer: software load when disarmed, hardware step on each non-final fetch
  assign nxt_start_addr = wr_start_addr ? reg_wdata[15:CRCG_ALIGN_LSB] :
                          (fetch_done && !at_end) ? addr_inc :
                          start_addr_ff;
  assign nxt_start_seg  = wr_start_seg ? reg_wdata[7:0] :
                          (fetch_done && !at_end) ? seg_inc :
                          start_seg_ff;

  // End of range: software only
  assign nxt_end_addr   = wr_end_addr ? reg_wdata[15:CRCG_ALIGN_LSB] : end_addr_ff;
  assign nxt_end_seg    = wr_end_seg  ? reg_wdata[7:0] : end_seg_ff;

  // Byte input keeps the last byte written
  assign nxt_byte_in    = wr_byte_in ? reg_wdata[7:0] : byte_in_ff;

  // Result: seed write, byte fold or word fold
  assign nxt_crc        = wr_result  ? reg_wdata :
                          wr_byte_in ? man_crc :
                          fetch_done ? word_crc :
                          crc_ff;

  // Enable: a software write in the completion cycle wins over the hardware clear
  assign nxt_aen        = wr_control ? reg_wdata[CRCG_AEN_BIT] :
                          range_done ? 1'b0 :
                          aen_ff;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped and odd addresses read zero; low address bits read zero
  assign nxt_rdata = !reg_rd        ? rdata_ff :
                     hit_start_addr ? {start_addr_ff, 2'b00} :
                     hit_end_addr   ? {end_addr_ff, 2'b00} :
                     hit_start_seg  ? {8'h00, start_seg_ff} :
                     hit_end_seg    ? {8'h00, end_seg_ff} :
                     hit_byte_in    ? {8'h00, byte_in_ff} :
                     hit_result     ? crc_ff :
                     hit_control    ? {15'h0000, aen_ff} :
                     16'h0000;

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  // Range and pointer registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      start_addr_ff <= CRCG_RST_START_ADDR[15:CRCG_ALIGN_LSB];
      end_addr_ff   <= CRCG_RST_END_ADDR[15:CRCG_ALIGN_LSB];
      start_seg_ff  <= CRCG_RST_START_SEG;
      end_seg_ff    <= CRCG_RST_END_SEG;
    end else begin
      start_addr_ff <= nxt_start_addr;
      end_addr_ff   <= nxt_end_addr;
      start_seg_ff  <= nxt_start_seg;
      end_seg_ff    <= nxt_end_seg;
    end
  end

  // Data, result and control registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      byte_in_ff <= CRCG_RST_BYTE_IN;
      crc_ff     <= CRCG_RST_RESULT;
      aen_ff     <= CRCG_RST_CONTROL[CRCG_AEN_BIT];
      scan_ff    <= CRCG_SCAN_IDLE;
      rdata_ff   <= 16'h0000;
    end else begin
      byte_in_ff <= nxt_byte_in;
      crc_ff     <= nxt_crc;
      aen_ff     <= nxt_aen;
      scan_ff    <= nxt_scan;
      rdata_ff   <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Fetch request stays up until the memory answers
  assign pm_req    = (scan_ff == CRCG_SCAN_FETCH);
  assign pm_seg    = start_seg_ff;
  assign pm_addr   = {start_addr_ff, 2'b00};
  assign reg_rdata = rdata_ff;
  assign auto_busy = aen_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Reset leaves the full default range and an all-ones seed
  a_reset_range: assert property (
    @(posedge core_clk) $rose(rst_b) |->
      (pm_addr == 16'h0000) && (end_addr_ff == 14'h3fff) && (end_seg_ff == 8'h0f) && (crc_ff == 16'hffff))
    else $error("reset range or seed wrong");

  // A byte write shows its folded result on the next edge
  a_byte_fold: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (reg_wr && !aen_ff && reg_addr == 16'hf0d8) |=> (crc_ff == $past(man_crc)))
    else $error("byte fold missing next cycle");

  // Armed scan drops end address writes
  a_locked_range: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (reg_wr && aen_ff && (reg_addr == 16'hf0d2)) |=> $stable(end_addr_ff))
    else $error("end address written while armed");

  // Armed scan drops seed writes
  a_locked_seed: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (reg_wr && aen_ff && (reg_addr == 16'hf0da) && !pm_ack) |=> $stable(crc_ff))
    else $error("result written while armed");

  // Address reads always show aligned values
  a_align_read: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (reg_rd && (reg_addr == 16'hf0d0 || reg_addr == 16'hf0d2)) |=> (reg_rdata[1:0] == 2'b00))
    else $error("address low bits not zero");

  // No fetch starts unless armed and halted
  a_scan_gate: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (!pm_req && !(aen_ff && cpu_halt)) |=> !pm_req)
    else $error("fetch without armed halt");

  // Each non-final fetch advances the pointer by one word
  a_ptr_step: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (pm_req && pm_ack && !at_end && !reg_wr) |=>
        ({pm_seg, pm_addr} == $past({pm_seg, pm_addr}) + 24'h00_0004))
    else $error("pointer did not step by four");

  // Final fetch clears the enable and stops requesting
  a_done_clear: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (pm_req && pm_ack && at_end && !wr_control) |=> (!aen_ff ##1 !pm_req))
    else $error("scan completion did not disarm");

  // Word fold lands in the result
  a_word_fold: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (pm_req && pm_ack) |=> (crc_ff == $past(word_crc)))
    else $error("fetched word not folded");

  // Result reads return the register one cycle later
  a_read_result: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == 16'hf0da) |=> (reg_rdata == $past(crc_ff)))
    else $error("result read wrong");

  // Armed scan drops start address writes outside fetch answers
  a_locked_start: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (reg_wr && aen_ff && (reg_addr == CRCG_OFS_START_ADDR) && !pm_ack) |=> $stable(start_addr_ff))
    else $error("start address written while armed");

  // Armed scan drops end segment writes
  a_locked_segment: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (reg_wr && aen_ff && (reg_addr == CRCG_OFS_END_SEG)) |=> $stable(end_seg_ff))
    else $error("end segment written while armed");

  // Armed scan drops data byte writes
  a_locked_byte: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (reg_wr && aen_ff && (reg_addr == CRCG_OFS_BYTE_IN)) |=> $stable(byte_in_ff))
    else $error("data byte written while armed");

  // Disarmed seed write loads the result as written
  a_seed_load: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (reg_wr && !aen_ff && (reg_addr == CRCG_OFS_RESULT)) |=> (crc_ff == $past(reg_wdata)))
    else $error("seed write not loaded");

  // Control writes take effect whatever the scan state
  a_ctrl_write: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (reg_wr && (reg_addr == CRCG_OFS_CONTROL)) |=> (aen_ff == $past(reg_wdata[CRCG_AEN_BIT])))
    else $error("enable bit not written");

  // A pending fetch holds its request and pointer
  a_req_hold: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (pm_req && !pm_ack && !reg_wr) |=> (pm_req && $stable(pm_seg) && $stable(pm_addr)))
    else $error("fetch request moved before answer");

  // The request drops right after each answer
  a_req_drop: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (pm_req && pm_ack) |=> !pm_req)
    else $error("request held after answer");

  // Without halt an idle scan stays idle
  a_pause_hold: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (!pm_req && !cpu_halt) |=> !pm_req)
    else $error("fetch started outside halt");

  // Armed and halted, an idle scan fetches next cycle
  a_scan_start: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (!pm_req && aen_ff && cpu_halt) |=> pm_req)
    else $error("armed halt did not start a fetch");

  // The final fetch leaves the pointer at the end
  a_end_hold: assert property (
    @(posedge core_clk) disable iff (!rst_b)
      (pm_req && pm_ack && at_end && !reg_wr) |=> $stable({pm_seg, pm_addr}))
    else $error("pointer moved past the end");

endmodule : crcg_top

// ### verification/crcg_pm_model.sv
`timescale 1ns/100ps

// Program memory stand-in: answers each fetch after a settable wait
module crcg_pm_model (
  input  wire logic        core_clk,  // System clock
  input  wire logic        pm_req,    // Fetch request
  input  wire logic [7:0]  pm_seg,    // Fetch segment
  input  wire logic [15:0] pm_addr,   // Fetch address
  input  wire logic [3:0]  ack_wait,  // Wait cycles before the answer
  output logic             pm_ack,    // Answer strobe
  output logic      [31:0] pm_rdata   // Word, defined with the answer only
);
  logic [3:0] wait_ff;

  initial begin
    pm_ack   = 1'h0;
    pm_rdata = 32'h0000_0000;
    wait_ff  = 4'h0;
  end

  // Answer when the wait runs out; data toggles outside answers so stale words never match
  always @(posedge core_clk) begin
    if (pm_req && !pm_ack && wait_ff == ack_wait) begin
      pm_ack   <= 1'h1;
      pm_rdata <= {pm_addr ^ 16'ha5c3, pm_seg, pm_addr[9:2]};
      wait_ff  <= 4'h0;
    end else begin
      pm_ack   <= 1'h0;
      pm_rdata <= ~pm_rdata;
      if (pm_req && !pm_ack) wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule : crcg_pm_model

// ### verification/tb_crcg_top.sv
`timescale 1ns/100ps

`define CHK(g, e, m) check_val(g, e, m)

// Self-checking bench for the CRC generator
module tb_crcg_top;
  import crcg_pkg::*;
  logic        core_clk, rst_b, reg_wr, reg_rd, cpu_halt, pm_req, pm_ack, auto_busy;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, pm_addr, rd_val, crc_exp;
  logic [7:0]  pm_seg;
  logic [31:0] pm_rdata;
  logic [3:0]  ack_wait;
  int          errors, comparisons;

  crcg_top DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_halt(cpu_halt), .pm_req(pm_req),
    .pm_seg(pm_seg), .pm_addr(pm_addr), .pm_ack(pm_ack), .pm_rdata(pm_rdata), .auto_busy(auto_busy));
  crcg_pm_model pm (.core_clk(core_clk), .pm_req(pm_req), .pm_seg(pm_seg), .pm_addr(pm_addr),
    .ack_wait(ack_wait), .pm_ack(pm_ack), .pm_rdata(pm_rdata));

  // Clock, 40 ns period
  always #20 core_clk = ~core_clk;

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // One-cycle bus cycles launched right after an edge
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;  // Word registers only at even addresses
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'h0;
  endtask : wr_reg

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e, input string what);
    @(posedge core_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'h0;
    #1 rd_val = reg_rdata;
    `CHK(rd_val, e, what);
  endtask : rd_chk

  task automatic set_halt(input logic h, input int cycles);
    @(posedge core_clk);
    cpu_halt <= h;
    repeat (cycles) @(posedge core_clk);
  endtask : set_halt

  task automatic wait_done;
    int n;
    n = 0;
    while (auto_busy !== 1'h0 && n < 2000) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n == 2000) begin
      errors++;
      $display("mismatch at %0t: scan never finished", $time);
      tally_and_finish();
    end
  endtask : wait_done

  // Reference CRC, reflected, one byte, bit 0 first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[i]) c = (c >> 1) ^ CRCG_POLY_REFL;
      else c = c >> 1;
    end
    return c;
  endfunction : crc_byte

  // Fold the model's word at seg:addr, lowest byte first
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [7:0] s, input logic [15:0] a);
    logic [31:0] w;
    w = {a ^ 16'ha5c3, s, a[9:2]};
    for (int b = 0; b < 4; b++) c = crc_byte(c, w[8*b +: 8]);
    return c;
  endfunction : crc_word

  task automatic test_reset;
    logic [15:0] ofs [9] = '{CRCG_OFS_START_ADDR, CRCG_OFS_END_ADDR, CRCG_OFS_START_SEG, CRCG_OFS_END_SEG,
      CRCG_OFS_BYTE_IN, CRCG_OFS_RESULT, CRCG_OFS_CONTROL, 16'hf0de, 16'hf0d1};
    logic [15:0] exp [9] = '{16'h0000, 16'hfffc, 16'h0000, 16'h000f, 16'h0000, 16'hffff, 16'h0000,
      16'h0000, 16'h0000};
    for (int i = 0; i < 9; i++) rd_chk(ofs[i], exp[i], "reset value");
    @(posedge core_clk);
    cpu_halt <= 1'h1;
    repeat (6) begin
      @(posedge core_clk);
      #1 `CHK(16'(pm_req), 16'h0000, "fetch with enable clear");
    end
    set_halt(1'h0, 1);
    $display("test reset done");
  endtask : test_reset

  task automatic test_manual;
    logic [7:0] bytes [11] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h81, 8'h7f};
    wr_reg(CRCG_OFS_RESULT, 16'hffff);
    crc_exp = 16'hffff;
    for (int i = 0; i < 11; i++) begin
      wr_reg(CRCG_OFS_BYTE_IN, {8'hab, bytes[i]});
      crc_exp = crc_byte(crc_exp, bytes[i]);
      rd_chk(CRCG_OFS_RESULT, crc_exp, "byte crc");
    end
    rd_chk(CRCG_OFS_BYTE_IN, 16'h007f, "byte register");
    $display("test manual done");
  endtask : test_manual

  task automatic test_align;
    wr_reg(CRCG_OFS_START_ADDR, 16'h1233);
    wr_reg(CRCG_OFS_END_ADDR, 16'h4567);
    rd_chk(CRCG_OFS_START_ADDR, 16'h1230, "start align");
    rd_chk(CRCG_OFS_END_ADDR, 16'h4564, "end align");
    $display("test align done");
  endtask : test_align

  task automatic test_scan_busy;
    @(posedge core_clk);
    ack_wait <= 4'h0;
    wr_reg(CRCG_OFS_START_ADDR, 16'h0000);
    wr_reg(CRCG_OFS_START_SEG, 16'h0000);
    wr_reg(CRCG_OFS_END_ADDR, 16'h0008);
    wr_reg(CRCG_OFS_END_SEG, 16'h0000);
    wr_reg(CRCG_OFS_RESULT, 16'h1d0f);
    wr_reg(CRCG_OFS_CONTROL, 16'h0001);
    for (int i = 0; i < 6; i++) wr_reg(CRCG_OFS_START_ADDR + 16'(2 * i), 16'h0134);
    rd_chk(CRCG_OFS_START_ADDR, 16'h0000, "start dropped");
    rd_chk(CRCG_OFS_END_ADDR, 16'h0008, "end dropped");
    rd_chk(CRCG_OFS_START_SEG, 16'h0000, "start seg dropped");
    rd_chk(CRCG_OFS_END_SEG, 16'h0000, "end seg dropped");
    rd_chk(CRCG_OFS_BYTE_IN, 16'h007f, "data dropped");
    rd_chk(CRCG_OFS_RESULT, 16'h1d0f, "result dropped");
    crc_exp = 16'h1d0f;
    for (int a = 0; a <= 8; a += 4) crc_exp = crc_word(crc_exp, 8'h00, 16'(a));
    set_halt(1'h1, 1);
    wait_done();
    set_halt(1'h0, 1);
    rd_chk(CRCG_OFS_CONTROL, 16'h0000, "enable cleared");
    rd_chk(CRCG_OFS_RESULT, crc_exp, "scan crc");
    rd_chk(CRCG_OFS_START_ADDR, 16'h0008, "pointer at end");
    $display("test scan busy done");
  endtask : test_scan_busy

  task automatic test_scan_pause;
    logic [15:0] p1;
    @(posedge core_clk);
    ack_wait <= 4'h3;
    wr_reg(CRCG_OFS_START_ADDR, 16'hfff8);
    wr_reg(CRCG_OFS_START_SEG, 16'h0001);
    wr_reg(CRCG_OFS_END_SEG, 16'h0002);
    wr_reg(CRCG_OFS_RESULT, 16'hffff);
    wr_reg(CRCG_OFS_CONTROL, 16'h0001);
    crc_exp = crc_word(crc_word(16'hffff, 8'h01, 16'hfff8), 8'h01, 16'hfffc);
    for (int a = 0; a <= 8; a += 4) crc_exp = crc_word(crc_exp, 8'h02, 16'(a));
    set_halt(1'h1, 11);
    set_halt(1'h0, 8);
    rd_chk(CRCG_OFS_START_ADDR, 16'h0000, "pointer mid scan");
    p1 = rd_val;
    repeat (10) @(posedge core_clk);
    rd_chk(CRCG_OFS_START_ADDR, p1, "pointer paused");
    rd_chk(CRCG_OFS_CONTROL, 16'h0001, "still enabled");
    set_halt(1'h1, 1);
    wait_done();
    set_halt(1'h0, 1);
    rd_chk(CRCG_OFS_RESULT, crc_exp, "resumed crc");
    rd_chk(CRCG_OFS_START_SEG, 16'h0002, "segment carry");
    $display("test scan pause done");
  endtask : test_scan_pause

  // Reset, then the scenarios in order
  initial begin
    core_clk    = 1'h0;
    rst_b       = 1'h0;
    reg_wr      = 1'h0;
    reg_rd      = 1'h0;
    reg_addr    = 16'h0000;
    reg_wdata   = 16'h0000;
    cpu_halt    = 1'h0;
    ack_wait    = 4'h0;
    errors      = 0;
    comparisons = 0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'h1;
    test_reset();
    test_manual();
    test_align();
    test_scan_busy();
    test_scan_pause();
    tally_and_finish();
  end
endmodule : tb_crcg_top
